// >>> hdl/aicc_pkg.sv
package aicc_pkg;

    // Bus geometry and result widths.
    localparam int ADDR_W = 8;
    localparam int DATA_W = 32;
    localparam int RES_W = 24;
    localparam int RAW_FRAC = 2;

    // Register byte offsets.
    localparam logic [7:0] OFS_CFG0 = 8'h00;
    localparam logic [7:0] OFS_CFG2 = 8'h04;
    localparam logic [7:0] OFS_INSEL = 8'h08;
    localparam logic [7:0] OFS_CMD = 8'h0c;
    localparam logic [7:0] OFS_STATUS = 8'h10;
    localparam logic [7:0] OFS_RESULT = 8'h14;

    // Field positions.
    localparam int CS_LSB = 0;
    localparam int MODE_LSB = 4;
    localparam int GAIN_LSB = 0;
    localparam int AZ_BIT = 3;
    localparam int START_BIT = 0;

    // Values after reset.
    localparam logic [7:0] CFG0_RST = 8'h00;
    localparam logic [7:0] CFG2_RST = 8'h01;
    localparam logic [7:0] INSEL_RST = 8'h01;

    // Codes.
    localparam logic [3:0] NIB_DIODE_P = 4'hd;
    localparam logic [3:0] NIB_DIODE_M = 4'he;
    localparam logic [7:0] TEMP_SEL = 8'hde;
    localparam logic [1:0] MODE_CONT = 2'h3;
    localparam logic [1:0] CS_OFF = 2'h0;
    localparam logic [2:0] GAIN_ANALOG_MAX = 3'h5;
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    // Conversion sequencer states.
    typedef enum logic [1:0] {ST_IDLE, ST_NORM, ST_SWAP} aicc_seq_state_type;

    // AXI4-Lite master to slave signals.
    typedef struct packed {
        logic awvalid;
        logic [ADDR_W-1:0] awaddr;
        logic wvalid;
        logic [DATA_W-1:0] wdata;
        logic [3:0] wstrb;
        logic bready;
        logic arvalid;
        logic [ADDR_W-1:0] araddr;
        logic rready;
    } aicc_axi_req_type;

    // AXI4-Lite slave to master signals.
    typedef struct packed {
        logic awready;
        logic wready;
        logic bvalid;
        logic [1:0] bresp;
        logic arready;
        logic rvalid;
        logic [DATA_W-1:0] rdata;
        logic [1:0] rresp;
    } aicc_axi_resp_type;

endpackage

// >>> hdl/aicc_gain_decode.sv
`timescale 1ns/1ps
`default_nettype none

// Splits the gain code into the analog stage setting and a digital shift.
module aicc_gain_decode (
    input wire logic [2:0] gain_code,
    output logic [2:0] analog_code,
    output logic [1:0] dig_shift
);
    import aicc_pkg::*;

    // Above the analog ceiling the remaining octaves become left shifts.
    always_comb begin
        if (gain_code > GAIN_ANALOG_MAX) begin
            analog_code = GAIN_ANALOG_MAX;
            dig_shift = 2'(gain_code - GAIN_ANALOG_MAX);
        end else begin
            analog_code = gain_code;
            dig_shift = 2'h0;
        end
    end

endmodule // aicc_gain_decode
`default_nettype wire

// >>> hdl/aicc_shift_round.sv
`timescale 1ns/1ps
`default_nettype none

// Applies digital gain by left shift, then rounds off the fraction bits.
module aicc_shift_round #(
    parameter int RAW_W = 26,
    parameter int OUT_W = 24,
    parameter int FRAC = 2
) (
    input wire logic signed [RAW_W-1:0] raw_code,
    input wire logic [1:0] shift,
    output logic signed [OUT_W-1:0] out_code
);
    localparam int EXT_W = RAW_W + 4;
    localparam logic signed [EXT_W-1:0] MAX_V = EXT_W'((1 << (OUT_W - 1)) - 1);
    localparam logic signed [EXT_W-1:0] MIN_V = -EXT_W'(1 << (OUT_W - 1));
    localparam logic signed [EXT_W-1:0] HALF = EXT_W'(1 << (FRAC - 1));

    generate
        if (FRAC < 1 || RAW_W < OUT_W + FRAC) begin : g_bad
            $error("aicc_shift_round: RAW_W must cover OUT_W plus FRAC, FRAC >= 1");
        end
    endgenerate

    logic signed [EXT_W-1:0] ext; // Sign-extended and shifted code.
    logic signed [EXT_W-1:0] rnd; // Rounded and scaled code.

    // No multiplier: a shift, a half-LSB add and saturation to the output span.
    always_comb begin
        ext = EXT_W'(raw_code) <<< shift;
        rnd = (ext + HALF) >>> FRAC;
        if (rnd > MAX_V) begin
            out_code = MAX_V[OUT_W-1:0];
        end else if (rnd < MIN_V) begin
            out_code = MIN_V[OUT_W-1:0];
        end else begin
            out_code = rnd[OUT_W-1:0];
        end
    end

endmodule // aicc_shift_round
`default_nettype wire

// >>> hdl/aicc_input_ctrl.sv
`timescale 1ns/1ps
`default_nettype none

// Behaviour
// - Burnout select sets 0, 0.9, 3.7, 15 uA.
// - Burnout source ignores conversion reset or shutdown.
// - Selector 0xDE connects the two temperature diodes.
// - Temperature selection disables burnout, enables diode bias.
// - Offset cancel resets off; off means no swap.
// - Cancel result is normal minus swapped, halved.
// - Offset cancel doubles conversion time per result.
// - Continuous with cancel resets filter between results.
// - Gain codes map to 0.333 through 64.
// - Top two codes keep analog 16x, shift digitally.
// - Digital gain is shift left and round.
// - Upper nibble positive input, lower nibble negative.
module aicc_input_ctrl #(
    parameter int RAW_W = 26
) (
    input wire logic core_clk,
    input wire logic sys_rst,
    input wire aicc_pkg::aicc_axi_req_type axi_req,
    output aicc_pkg::aicc_axi_resp_type axi_resp,
    input wire logic scan_temp_sel,
    input wire logic conv_halt,
    input wire logic conv_done,
    input wire logic signed [RAW_W-1:0] conv_raw,
    output logic conv_start,
    output logic filter_reset,
    output logic swap_inputs,
    output logic data_ready,
    output logic [1:0] burnout_mag,
    output logic diode_bias_en,
    output logic [3:0] pos_input_sel,
    output logic [3:0] neg_input_sel,
    output logic [2:0] analog_gain
);
    import aicc_pkg::*;

    // Bus channel state.
    logic aw_held_reg, aw_held_next; // Write address taken, awaiting write.
    logic w_held_reg, w_held_next; // Write data taken, awaiting write.
    logic [ADDR_W-1:0] awaddr_reg, awaddr_next;
    logic [7:0] wbyte_reg, wbyte_next; // Only byte lane 0 carries fields.
    logic wlane_reg, wlane_next; // Lane 0 strobe of the held write.
    logic bvalid_reg, bvalid_next;
    logic [1:0] bresp_reg, bresp_next;
    logic rvalid_reg, rvalid_next;
    logic [DATA_W-1:0] rdata_reg, rdata_next;
    logic [1:0] rresp_reg, rresp_next;

    // Software configuration.
    logic [7:0] config_word_zero_reg, config_word_zero_next;
    logic [7:0] config_word_two_reg, config_word_two_next;
    logic [7:0] input_selector_reg, input_selector_next;

    // Conversion sequencer state.
    aicc_seq_state_type st_reg, st_next;
    logic az_run_reg, az_run_next; // Offset cancel latched per request.
    logic start_reg, start_next;
    logic filt_reg, filt_next;
    logic swap_reg, swap_next;
    logic rdy_reg, rdy_next;
    logic valid_reg, valid_next; // Unread result flag.
    logic signed [RES_W-1:0] norm_reg, norm_next; // Normal-polarity code.
    logic signed [RES_W-1:0] result_reg, result_next;

    // Analog steering outputs.
    logic [1:0] burn_reg, burn_next;
    logic bias_reg, bias_next;
    logic [3:0] pos_reg, pos_next;
    logic [3:0] neg_reg, neg_next;
    logic [2:0] again_reg, again_next;

    // Shared combinational terms.
    logic wr_fire; // A held address and data pair is written now.
    logic start_req; // Software asks for a conversion.
    logic rd_result; // Result register read taken now.
    logic temp_sel; // Temperature sensor is chosen.
    logic cont_mode;
    logic [1:0] dig_shift;
    logic [2:0] an_code;
    logic signed [RES_W-1:0] shifted; // Gain-applied filter code.
    logic signed [RES_W:0] az_diff; // Normal minus swapped.

    aicc_gain_decode u_gain (
        .gain_code(config_word_two_reg[GAIN_LSB +: 3]),
        .analog_code(an_code),
        .dig_shift(dig_shift)
    );

    aicc_shift_round #(.RAW_W(RAW_W), .OUT_W(RES_W), .FRAC(RAW_FRAC)) u_shift (
        .raw_code(conv_raw),
        .shift(dig_shift),
        .out_code(shifted)
    );

    assign wr_fire = aw_held_reg && w_held_reg && !bvalid_reg;
    assign start_req = wr_fire && wlane_reg && awaddr_reg == OFS_CMD && wbyte_reg[START_BIT];
    assign rd_result = axi_req.arvalid && !rvalid_reg && axi_req.araddr == OFS_RESULT;
    assign cont_mode = config_word_zero_reg[MODE_LSB +: 2] == MODE_CONT;
    assign az_diff = (RES_W+1)'(norm_reg) - (RES_W+1)'(shifted);
    // Either nibble on a diode code counts as the sensor being chosen.
    assign temp_sel = scan_temp_sel || input_selector_reg[7:4] == NIB_DIODE_P
        || input_selector_reg[3:0] == NIB_DIODE_M;

    // Bus: address and data are taken in either order, answered once both held.
    always_comb begin
        aw_held_next = aw_held_reg;
        w_held_next = w_held_reg;
        awaddr_next = awaddr_reg;
        wbyte_next = wbyte_reg;
        wlane_next = wlane_reg;
        bvalid_next = bvalid_reg;
        bresp_next = bresp_reg;
        rvalid_next = rvalid_reg;
        rdata_next = rdata_reg;
        rresp_next = rresp_reg;
        config_word_zero_next = config_word_zero_reg;
        config_word_two_next = config_word_two_reg;
        input_selector_next = input_selector_reg;
        if (axi_req.awvalid && !aw_held_reg && !bvalid_reg) begin
            aw_held_next = 1'b1;
            awaddr_next = axi_req.awaddr;
        end
        if (axi_req.wvalid && !w_held_reg && !bvalid_reg) begin
            w_held_next = 1'b1;
            wbyte_next = axi_req.wdata[7:0];
            wlane_next = axi_req.wstrb[0];
        end
        if (wr_fire) begin
            aw_held_next = 1'b0;
            w_held_next = 1'b0;
            bvalid_next = 1'b1;
            bresp_next = RESP_OKAY;
            // The burnout field may be rewritten at any moment.
            case (awaddr_reg)
                OFS_CFG0: if (wlane_reg) config_word_zero_next = wbyte_reg;
                OFS_CFG2: if (wlane_reg) config_word_two_next = wbyte_reg;
                OFS_INSEL: if (wlane_reg) input_selector_next = wbyte_reg;
                OFS_CMD: bresp_next = RESP_OKAY;
                default: bresp_next = RESP_SLVERR;
            endcase
        end else if (bvalid_reg && axi_req.bready) begin
            bvalid_next = 1'b0;
        end
        if (axi_req.arvalid && !rvalid_reg) begin
            rvalid_next = 1'b1;
            rresp_next = RESP_OKAY;
            case (axi_req.araddr)
                OFS_CFG0: rdata_next = DATA_W'(config_word_zero_reg);
                OFS_CFG2: rdata_next = DATA_W'(config_word_two_reg);
                OFS_INSEL: rdata_next = DATA_W'(input_selector_reg);
                OFS_CMD: rdata_next = '0;
                OFS_STATUS: rdata_next = DATA_W'({valid_reg, st_reg != ST_IDLE, bias_reg,
                    burn_reg});
                OFS_RESULT: rdata_next = DATA_W'(result_reg);
                default: begin
                    rdata_next = '0;
                    rresp_next = RESP_SLVERR;
                end
            endcase
        end else if (rvalid_reg && axi_req.rready) begin
            rvalid_next = 1'b0;
        end
    end

    // Bus and configuration registers.
    always_ff @(posedge core_clk or posedge sys_rst) begin
        if (sys_rst) begin
            aw_held_reg <= 1'b0;
            w_held_reg <= 1'b0;
            awaddr_reg <= '0;
            wbyte_reg <= 8'h00;
            wlane_reg <= 1'b0;
            bvalid_reg <= 1'b0;
            bresp_reg <= RESP_OKAY;
            rvalid_reg <= 1'b0;
            rdata_reg <= '0;
            rresp_reg <= RESP_OKAY;
            config_word_zero_reg <= CFG0_RST;
            config_word_two_reg <= CFG2_RST;
            input_selector_reg <= INSEL_RST;
        end else begin
            aw_held_reg <= aw_held_next;
            w_held_reg <= w_held_next;
            awaddr_reg <= awaddr_next;
            wbyte_reg <= wbyte_next;
            wlane_reg <= wlane_next;
            bvalid_reg <= bvalid_next;
            bresp_reg <= bresp_next;
            rvalid_reg <= rvalid_next;
            rdata_reg <= rdata_next;
            rresp_reg <= rresp_next;
            config_word_zero_reg <= config_word_zero_next;
            config_word_two_reg <= config_word_two_next;
            input_selector_reg <= input_selector_next;
        end
    end

    // Sequencer: one conversion per result, or a normal/swapped pair when
    // offset cancel is on. A halt drops the request but keeps any result.
    always_comb begin
        st_next = st_reg;
        az_run_next = az_run_reg;
        start_next = 1'b0;
        filt_next = 1'b0;
        swap_next = swap_reg;
        rdy_next = 1'b0;
        norm_next = norm_reg;
        result_next = result_reg;
        valid_next = valid_reg && !rd_result;
        case (st_reg)
            ST_IDLE: begin
                swap_next = 1'b0;
                if (start_req) begin
                    st_next = ST_NORM;
                    az_run_next = config_word_two_reg[AZ_BIT];
                    start_next = 1'b1;
                    filt_next = config_word_two_reg[AZ_BIT];
                end
            end
            ST_NORM: begin
                if (conv_done && az_run_reg) begin
                    // Swapped half starts at once; no result yet.
                    norm_next = shifted;
                    st_next = ST_SWAP;
                    swap_next = 1'b1;
                    start_next = 1'b1;
                    filt_next = 1'b1;
                end else if (conv_done) begin
                    result_next = shifted;
                    rdy_next = 1'b1;
                    valid_next = 1'b1;
                    // Without cancel the filter just keeps running in continuous mode.
                    st_next = cont_mode ? ST_NORM : ST_IDLE;
                end
            end
            ST_SWAP: begin
                if (conv_done) begin
                    result_next = az_diff[RES_W:1];
                    rdy_next = 1'b1;
                    valid_next = 1'b1;
                    swap_next = 1'b0;
                    if (cont_mode) begin
                        // Back-to-back one-shot pairs, filter cleared each time.
                        st_next = ST_NORM;
                        start_next = 1'b1;
                        filt_next = 1'b1;
                    end else begin
                        st_next = ST_IDLE;
                    end
                end
            end
            default: st_next = ST_IDLE;
        endcase
        if (conv_halt) begin
            st_next = ST_IDLE;
            start_next = 1'b0;
            filt_next = 1'b0;
            swap_next = 1'b0;
        end
    end

    // Sequencer registers.
    always_ff @(posedge core_clk or posedge sys_rst) begin
        if (sys_rst) begin
            st_reg <= ST_IDLE;
            az_run_reg <= 1'b0;
            start_reg <= 1'b0;
            filt_reg <= 1'b0;
            swap_reg <= 1'b0;
            rdy_reg <= 1'b0;
            valid_reg <= 1'b0;
            norm_reg <= '0;
            result_reg <= '0;
        end else begin
            st_reg <= st_next;
            az_run_reg <= az_run_next;
            start_reg <= start_next;
            filt_reg <= filt_next;
            swap_reg <= swap_next;
            rdy_reg <= rdy_next;
            valid_reg <= valid_next;
            norm_reg <= norm_next;
            result_reg <= result_next;
        end
    end

    // Steering: the burnout source looks only at configuration and scan_temp_sel, never at the
    // sequencer or the halt, so it stays on through converter reset.
    always_comb begin
        burn_next = temp_sel ? CS_OFF : config_word_zero_reg[CS_LSB +: 2];
        bias_next = temp_sel;
        if (scan_temp_sel) begin
            pos_next = NIB_DIODE_P;
            neg_next = NIB_DIODE_M;
        end else begin
            pos_next = input_selector_reg[7:4];
            neg_next = input_selector_reg[3:0];
        end
        again_next = an_code;
    end

    // Steering registers.
    always_ff @(posedge core_clk or posedge sys_rst) begin
        if (sys_rst) begin
            burn_reg <= CS_OFF;
            bias_reg <= 1'b0;
            pos_reg <= INSEL_RST[7:4];
            neg_reg <= INSEL_RST[3:0];
            again_reg <= CFG2_RST[2:0];
        end else begin
            burn_reg <= burn_next;
            bias_reg <= bias_next;
            pos_reg <= pos_next;
            neg_reg <= neg_next;
            again_reg <= again_next;
        end
    end

    assign axi_resp = '{awready: !aw_held_reg && !bvalid_reg, wready: !w_held_reg && !bvalid_reg,
        bvalid: bvalid_reg, bresp: bresp_reg, arready: !rvalid_reg, rvalid: rvalid_reg,
        rdata: rdata_reg, rresp: rresp_reg};
    assign conv_start = start_reg;
    assign filter_reset = filt_reg;
    assign swap_inputs = swap_reg;
    assign data_ready = rdy_reg;
    assign burnout_mag = burn_reg;
    assign diode_bias_en = bias_reg;
    assign pos_input_sel = pos_reg;
    assign neg_input_sel = neg_reg;
    assign analog_gain = again_reg;

    default clocking cb @(posedge core_clk); endclocking
    default disable iff (sys_rst);

    // First half of a cancelled pair ends.
    sequence s_norm_done;
        conv_done && st_reg == ST_NORM && az_run_reg && !conv_halt;
    endsequence

    // Swapped half is launched on the next edge.
    sequence s_swap_start;
        start_reg && swap_reg && st_reg == ST_SWAP && !data_ready;
    endsequence

    a_burnout_follows: assert property (!temp_sel ##1 !temp_sel |-> burn_reg ==
        $past(config_word_zero_reg[CS_LSB +: 2])) else $error("burnout magnitude wrong");
    a_burnout_halt_on: assert property (conv_halt && !temp_sel
        && config_word_zero_reg[1:0] != CS_OFF |=> burn_reg != CS_OFF)
        else $error("burnout dropped during halt");
    a_diode_code_map: assert property (input_selector_reg == TEMP_SEL
        && !scan_temp_sel |=> pos_reg == NIB_DIODE_P && neg_reg == NIB_DIODE_M)
        else $error("diode code not steered");
    a_temp_kills_burn: assert property (temp_sel |=>
        burn_reg == CS_OFF && bias_reg) else $error("burnout on with temp sensor");
    a_no_swap_off: assert property (start_reg && !az_run_reg |->
        !swap_reg && !filt_reg) else $error("swap without offset cancel");
    a_az_combine_val: assert property (conv_done && st_reg == ST_SWAP
        && !conv_halt |=> data_ready && result_reg == $past(az_diff[RES_W:1]))
        else $error("bad cancel result");
    a_pair_no_early: assert property (s_norm_done |=> s_swap_start)
        else $error("swapped half not started at once");
    a_cont_pair_reset: assert property (conv_done && st_reg == ST_SWAP && cont_mode
        && !conv_halt |=> start_reg && filter_reset && !swap_reg)
        else $error("no filter reset in pair");
    a_gain_split_top: assert property (config_word_two_reg[2:0] == 3'h7 |->
        dig_shift == 2'h2 ##1 again_reg == GAIN_ANALOG_MAX) else $error("bad top gain");
    a_plain_result: assert property (conv_done && st_reg == ST_NORM
        && !az_run_reg && !conv_halt |=> data_ready && result_reg == $past(shifted))
        else $error("plain result wrong");
    a_nibble_steer: assert property (!scan_temp_sel |=>
        pos_reg == $past(input_selector_reg[7:4])
        && neg_reg == $past(input_selector_reg[3:0])) else $error("nibble steering wrong");

endmodule // aicc_input_ctrl
`default_nettype wire

// >>> verif/adc_input_conditioning_ctrl_bench.sv
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, b) begin checks_done++; if ((a) !== (b)) begin n_fail++; \
    $display("ERROR %0t: got %h expected %h", $time, (a), (b)); end end

// Self-checking bench: drives the register bus and the converter link, models results.
module adc_input_conditioning_ctrl_bench;
    import aicc_pkg::*;
    logic core_clk; // Bench clock, 50 ns period.
    logic sys_rst; // Active high reset.
    aicc_axi_req_type req; // Master side of the register bus.
    aicc_axi_resp_type rsp; // Slave answers.
    logic scan_temp_sel, conv_halt, conv_done; // Converter side inputs.
    logic signed [25:0] conv_raw; // Filter code handed with each done pulse.
    logic conv_start, filter_reset, swap_inputs, data_ready; // Sequencer outputs.
    logic [1:0] burnout_mag; // Effective burnout code.
    logic diode_bias_en; // Diode bias source.
    logic [3:0] pos_input_sel, neg_input_sel; // Selector outputs.
    logic [2:0] analog_gain; // Analog stage code.
    int n_fail = 0; // Mismatches seen.
    int checks_done = 0; // Comparisons made.
    int n_ready = 0; // Data ready pulses seen.
    int n0, s, i, g, az; // Loop and bookkeeping values.
    logic [1:0] start_q[$]; // Swap and filter reset flags seen with each start.
    logic [31:0] rd; // Read data.
    logic [1:0] rr; // Response code.
    longint a, b, e; // Raw halves and expected result.

    aicc_input_ctrl #(.RAW_W(26)) aicc_input_ctrl_inst (.core_clk(core_clk), .sys_rst(sys_rst),
        .axi_req(req), .axi_resp(rsp), .scan_temp_sel(scan_temp_sel), .conv_halt(conv_halt),
        .conv_done(conv_done), .conv_raw(conv_raw), .conv_start(conv_start),
        .filter_reset(filter_reset), .swap_inputs(swap_inputs), .data_ready(data_ready),
        .burnout_mag(burnout_mag), .diode_bias_en(diode_bias_en),
        .pos_input_sel(pos_input_sel), .neg_input_sel(neg_input_sel),
        .analog_gain(analog_gain));

    // The clock toggles every half period.
    initial begin
        core_clk = 1'b0;
        forever #25 core_clk = ~core_clk;
    end

    // Pulses are counted at the edge that samples them, so no check depends on process order.
    always @(posedge core_clk) begin
        if (data_ready === 1'b1) n_ready++;
        if (conv_start === 1'b1) start_q.push_back({swap_inputs, filter_reset});
    end

    // Gain shift and rounding with saturation, worked out with integers.
    function automatic longint gscale(longint raw, int sh);
        longint v;
        v = ((raw <<< sh) + 2) >>> 2;
        if (v > 8388607) v = 8388607;
        if (v < -8388608) v = -8388608;
        return v;
    endfunction

    // Prints the verdict and ends the run.
    task automatic results();
        if (n_fail == 0 && checks_done > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask

    // Write one word; address and data are offered together and released as taken.
    task automatic axw(input logic [7:0] ad, input logic [31:0] d);
        int t;
        @(posedge core_clk);
        req.awvalid <= 1'b1; req.awaddr <= ad; req.wvalid <= 1'b1;
        req.wdata <= d; req.wstrb <= 4'hf; req.bready <= 1'b1;
        for (t = 0; t < 50; t++) begin
            @(posedge core_clk);
            if (rsp.awready) req.awvalid <= 1'b0;
            if (rsp.wready) req.wvalid <= 1'b0;
            if (rsp.bvalid) break;
        end
        if (t == 50) begin n_fail++; results(); end
        rr = rsp.bresp;
        req.bready <= 1'b0;
    endtask

    // Read one word; data and response are taken at the edge that sees rvalid.
    task automatic axr(input logic [7:0] ad);
        int t;
        @(posedge core_clk);
        req.arvalid <= 1'b1; req.araddr <= ad; req.rready <= 1'b1;
        for (t = 0; t < 50; t++) begin
            @(posedge core_clk);
            if (rsp.arready) req.arvalid <= 1'b0;
            if (rsp.rvalid) break;
        end
        if (t == 50) begin n_fail++; results(); end
        rd = rsp.rdata; rr = rsp.rresp;
        req.rready <= 1'b0;
    endtask

    // One converter done pulse carrying a raw code.
    task automatic done(input longint raw);
        @(posedge core_clk);
        conv_done <= 1'b1; conv_raw <= 26'(raw);
        @(posedge core_clk);
        conv_done <= 1'b0;
    endtask

    // Bounded wait for a count of starts (sel 0) or of ready pulses (sel 1).
    task automatic wait_n(input bit sel, input int n);
        int t;
        for (t = 0; t < 40 && (sel ? n_ready : start_q.size()) < n; t++) @(posedge core_clk);
        if (t == 40) begin n_fail++; results(); end
    endtask

    // Main sequence.
    initial begin
        req = '0; scan_temp_sel = 1'b0; conv_halt = 1'b0; conv_done = 1'b0; conv_raw = '0;
        sys_rst = 1'b1;
        void'($urandom(98));
        repeat (2) @(posedge core_clk);
        sys_rst <= 1'b0;
        axr(OFS_CFG2);
        `CHK(rd, 32'h1);
        // Burnout codes while the converter is halted: the source must not care.
        conv_halt <= 1'b1;
        for (i = 0; i < 4; i++) begin
            axw(OFS_CFG0, 32'(i));
            @(posedge core_clk); #1;
            `CHK(burnout_mag, 2'(i));
            axr(OFS_STATUS);
            `CHK(rd[1:0], 2'(i));
        end
        conv_halt <= 1'b0;
        axw(OFS_INSEL, {24'h0, TEMP_SEL});
        @(posedge core_clk); #1;
        `CHK({burnout_mag, diode_bias_en}, 3'b001);
        `CHK({pos_input_sel, neg_input_sel}, 8'hde);
        axr(OFS_CFG0);
        `CHK(rd[1:0], 2'h3);
        axw(OFS_INSEL, 32'h23);
        @(posedge core_clk); #1;
        `CHK({pos_input_sel, neg_input_sel, burnout_mag}, 10'h08f);
        @(posedge core_clk);
        scan_temp_sel <= 1'b1;
        repeat (2) @(posedge core_clk); #1;
        `CHK({pos_input_sel, neg_input_sel, burnout_mag}, 10'h378);
        @(posedge core_clk);
        scan_temp_sel <= 1'b0;
        // Unmapped place: refused with an error code and zero data.
        axr(8'h20);
        `CHK({rr, rd}, {RESP_SLVERR, 32'h0});
        // Every gain code, one-shot, with and without offset cancellation.
        for (g = 0; g < 8; g++) for (az = 0; az < 2; az++) begin
            s = (g == 6) ? 1 : (g == 7) ? 2 : 0;
            axw(OFS_CFG2, 32'(az * 8 + g));
            @(posedge core_clk); #1;
            `CHK(analog_gain, 3'((g > 5) ? 5 : g));
            start_q.delete(); n0 = n_ready;
            axw(OFS_CMD, 32'h1);
            a = longint'($signed(26'($urandom))); b = longint'($signed(26'($urandom)));
            wait_n(0, 1);
            done(a);
            e = gscale(a, s);
            if (az == 1) begin
                wait_n(0, 2);
                `CHK(n_ready, n0);
                done(b);
                e = (gscale(a, s) - gscale(b, s)) >>> 1;
            end
            wait_n(1, n0 + 1);
            `CHK(start_q.size(), az + 1);
            `CHK(start_q[az], (az == 1) ? 2'b11 : 2'b00);
            axr(OFS_RESULT);
            // The result register reads back sign-extended to the full word.
            `CHK(rd, 32'(e));
        end
        // Continuous mode with cancellation restarts as one-shot pairs with a filter reset.
        axw(OFS_CFG0, 32'h30);
        axw(OFS_CFG2, 32'h09);
        start_q.delete(); n0 = n_ready;
        axw(OFS_CMD, 32'h1);
        a = longint'($signed(26'($urandom))); b = longint'($signed(26'($urandom)));
        wait_n(0, 1);
        done(a);
        wait_n(0, 2);
        done(b);
        wait_n(1, n0 + 1);
        wait_n(0, 3);
        `CHK(start_q[2], 2'b01);
        axr(OFS_RESULT);
        `CHK(rd, 32'((gscale(a, 0) - gscale(b, 0)) >>> 1));
        conv_halt <= 1'b1;
        results();
    end
endmodule // adc_input_conditioning_ctrl_bench
`default_nettype wire
